// ### logic/dfz_pkg.sv
package dfz_pkg;
	// control port register indexes
	localparam logic [6:0] REG_INDEX_ATTEN_CTRL = 7'h12;
	localparam logic [6:0] REG_INDEX_FORMAT     = 7'h14;
	localparam logic [6:0] REG_INDEX_READBACK   = 7'h15;
	localparam logic [6:0] REG_INDEX_AUTO_FIRST = 7'h01;
	localparam int         ZERO_MUTE_BIT        = 4;
	localparam logic [7:0] ATTEN_CTRL_RESET     = 8'h00;
	localparam logic [7:0] FORMAT_RESET         = 8'h00;
	localparam logic [7:0] READBACK_RESET       = 8'h81 & 8'h7f;
	localparam logic [7:0] UNMAPPED_READ        = 8'h00;
	// control word layout
	localparam int         CTL_WORD_BITS        = 16;
	localparam int         CTL_HEADER_BITS      = 8;
	localparam int         CTL_RW_BIT           = 15;
	// audio word formats
	localparam logic [2:0] FORMAT_RJ24          = 3'h0;
	localparam logic [2:0] FORMAT_RJ20          = 3'h1;
	localparam logic [2:0] FORMAT_RJ18          = 3'h2;
	localparam logic [2:0] FORMAT_RJ16          = 3'h3;
	localparam logic [2:0] FORMAT_I2S           = 3'h4;
	localparam logic [2:0] FORMAT_RJ_ANY        = 3'h5;
	localparam logic [1:0] ROLLOFF_SHARP        = 2'h0;
	localparam logic [1:0] ROLLOFF_SLOW1        = 2'h1;
	localparam logic [1:0] ROLLOFF_SLOW2        = 2'h2;
	localparam logic       INTERP_8X            = 1'b0;
	localparam logic       INTERP_4X            = 1'b1;
	localparam int         SAMPLE_BITS          = 24;
	localparam int         I2S_FIRST_POS        = 1;
	localparam int         ZERO_RUN_PERIODS     = 1024;

	typedef struct packed {
		logic       interp_rate_select;
		logic [1:0] filter_rolloff_select;
		logic       clock_out_halve;
		logic       clock_out_disable;
		logic [2:0] audio_word_format;
	} dfz_format_s;

	typedef struct packed {
		logic       auto_step;
		logic [6:0] target_index;
	} dfz_readback_s;

	typedef struct packed {
		logic        valid;
		logic        right;
		logic [23:0] data;
	} dfz_sample_s;

	typedef struct packed {
		logic ctl_latch_n;
		logic ctl_clk;
		logic ctl_data;
		logic bit_clk;
		logic word_clock;
		logic audio_data;
		logic sys_clk_in;
	} dfz_pins_s;
endpackage

// ### logic/dfz_converter_ctrl.sv
// What this block does
// - three-bit code picks the serial word format
// - clock-out pin driven at 0, floated at 1
// - clock-out full rate at 0, half at 1
// - two-bit field picks sharp or slow roll-off
// - interpolation 8x at 0, 4x at 1
// - word top bit: 0 write, 1 read
// - bits 14-8 index, bits 7-0 data
// - readback bit 7 auto-step, bits 6-0 target
// - auto-step 1 gives auto-increment reads
// - single read returns target register, reset 01h
// - auto-increment read ends at target index
// - zero after 1024 all-zero word periods per channel
// - zero condition drives channel zero flag high
// - mute enabled and zero forces bipolar zero
// - zero-detect mute disabled after reset
// - mute enable never affects zero flags
// - mute enable lives in attenuator control register
`timescale 1ns/1ns
module dfz_converter_ctrl (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_reset_n,
	input  wire logic                 i_clk_en,
	input  wire logic                 i_ctl_latch_n,
	input  wire logic                 i_ctl_clk,
	input  wire logic                 i_ctl_data,
	input  wire logic                 i_bit_clk,
	input  wire logic                 i_word_clock,
	input  wire logic                 i_audio_data,
	input  wire logic                 i_sys_clk_in,
	output logic                      o_ctl_data_out,
	output logic                      o_ctl_data_out_oe,
	output logic                      o_system_clock_output,
	output logic                      o_system_clock_output_oe,
	output logic [1:0]                o_filter_rolloff_select,
	output logic                      o_interp_rate_select,
	output dfz_pkg::dfz_sample_s      o_sample,
	output logic                      o_left_zero_flag,
	output logic                      o_right_zero_flag
);
	import dfz_pkg::*;

	typedef enum logic [1:0] {CP_IDLE, CP_HEADER, CP_WRITE, CP_READ} dfz_cp_e;

	function automatic logic [7:0] read_reg(input logic [6:0] idx, input dfz_format_s fmt,
		input dfz_readback_s rb, input logic mute_en);
		logic [7:0] v;
		v = UNMAPPED_READ;
		case (idx)
			REG_INDEX_ATTEN_CTRL: v[ZERO_MUTE_BIT] = mute_en;
			REG_INDEX_FORMAT:     v = fmt;
			REG_INDEX_READBACK:   v = rb;
			default:              v = UNMAPPED_READ;
		endcase
		return v;
	endfunction

	function automatic logic [23:0] align_sample(input logic [2:0] f, input logic [31:0] sr,
		input logic [23:0] i2s);
		logic [23:0] v;
		v = sr[23:0];
		case (f)
			FORMAT_RJ20: v = {sr[19:0], 4'h0};
			FORMAT_RJ18: v = {sr[17:0], 6'h00};
			FORMAT_RJ16: v = {sr[15:0], 8'h00};
			FORMAT_I2S:  v = i2s;
			default:     v = sr[23:0];
		endcase
		return v;
	endfunction

	// pin synchronisers; stage three feeds edge detection and the word clock channel select
	dfz_pins_s pin_s1_q, pin_s2_q, pin_s3_q;
	dfz_pins_s pin_now;
	localparam dfz_pins_s PIN_RESET = '{ctl_latch_n: 1'b1, default: 1'b0};
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pin_s1_q <= PIN_RESET;
			pin_s2_q <= PIN_RESET;
			pin_s3_q <= PIN_RESET;
		end
		else if (i_clk_en)
		begin
			pin_s1_q <= pin_now;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign pin_now = '{i_ctl_latch_n, i_ctl_clk, i_ctl_data, i_bit_clk, i_word_clock,
		i_audio_data, i_sys_clk_in};
	wire ctl_clk_rise = pin_s2_q.ctl_clk & ~pin_s3_q.ctl_clk;
	wire bit_clk_rise = pin_s2_q.bit_clk & ~pin_s3_q.bit_clk;
	wire word_edge    = pin_s2_q.word_clock ^ pin_s3_q.word_clock;
	wire sclk_rise    = pin_s2_q.sys_clk_in & ~pin_s3_q.sys_clk_in;

	// control port and register file
	dfz_cp_e       cp_q, cp_d;
	logic [15:0]   cmd_q, cmd_d;
	logic [3:0]    hdr_cnt_q, hdr_cnt_d;
	logic [2:0]    bit_cnt_q, bit_cnt_d;
	logic [7:0]    out_sr_q, out_sr_d;
	logic [6:0]    rd_idx_q, rd_idx_d;
	logic          dout_oe_q, dout_oe_d;
	dfz_format_s   fmt_q, fmt_d;
	dfz_readback_s rb_q, rb_d;
	logic          mute_en_q, mute_en_d;
	logic [15:0]   cmd_next;

	always_comb
	begin
		cp_d      = cp_q;
		cmd_d     = cmd_q;
		hdr_cnt_d = hdr_cnt_q;
		bit_cnt_d = bit_cnt_q;
		out_sr_d  = out_sr_q;
		rd_idx_d  = rd_idx_q;
		dout_oe_d = dout_oe_q;
		fmt_d     = fmt_q;
		rb_d      = rb_q;
		mute_en_d = mute_en_q;
		cmd_next  = {cmd_q[14:0], pin_s2_q.ctl_data};
		if (pin_s2_q.ctl_latch_n)
		begin
			// latch high ends any frame; a partial word is dropped
			cp_d      = CP_IDLE;
			dout_oe_d = 1'b0;
		end
		else
		begin
			case (cp_q)
				CP_IDLE:
				begin
					cp_d      = CP_HEADER;
					hdr_cnt_d = '0;
					bit_cnt_d = '0;
				end
				CP_HEADER:
				begin
					if (ctl_clk_rise)
					begin
						cmd_d     = cmd_next;
						hdr_cnt_d = hdr_cnt_q + 4'h1;
						if (hdr_cnt_q == 4'(CTL_HEADER_BITS - 1))
						begin
							if (cmd_next[CTL_HEADER_BITS - 1])
							begin
								// single read uses the target, auto read starts at one
								rd_idx_d  = rb_q.auto_step ? REG_INDEX_AUTO_FIRST
									: rb_q.target_index;
								out_sr_d  = read_reg(rb_q.auto_step ? REG_INDEX_AUTO_FIRST
									: rb_q.target_index, fmt_q, rb_q, mute_en_q);
								dout_oe_d = 1'b1;
								cp_d      = CP_READ;
							end
							else
								cp_d = CP_WRITE;
						end
					end
				end
				CP_WRITE:
				begin
					if (ctl_clk_rise)
					begin
						cmd_d     = cmd_next;
						bit_cnt_d = bit_cnt_q + 3'h1;
						if (bit_cnt_q == 3'h7)
						begin
							case (cmd_next[14:8])
								REG_INDEX_ATTEN_CTRL: mute_en_d = cmd_next[ZERO_MUTE_BIT];
								REG_INDEX_FORMAT:     fmt_d = cmd_next[7:0];
								REG_INDEX_READBACK:   rb_d = cmd_next[7:0];
								default:              ;
							endcase
							// one word per frame; later bits are ignored
							cp_d = CP_READ;
						end
					end
				end
				CP_READ:
				begin
					if (ctl_clk_rise && dout_oe_q)
					begin
						out_sr_d  = {out_sr_q[6:0], 1'b0};
						bit_cnt_d = bit_cnt_q + 3'h1;
						if (bit_cnt_q == 3'h7)
						begin
							if (rb_q.auto_step && rd_idx_q < rb_q.target_index)
							begin
								rd_idx_d = rd_idx_q + 7'h1;
								out_sr_d = read_reg(rd_idx_q + 7'h1, fmt_q, rb_q, mute_en_q);
							end
							else
								dout_oe_d = 1'b0;
						end
					end
				end
				default: cp_d = CP_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cp_q      <= CP_IDLE;
			cmd_q     <= '0;
			hdr_cnt_q <= '0;
			bit_cnt_q <= '0;
			out_sr_q  <= '0;
			rd_idx_q  <= '0;
			dout_oe_q <= 1'b0;
			fmt_q     <= FORMAT_RESET;
			rb_q      <= READBACK_RESET;
			mute_en_q <= ATTEN_CTRL_RESET[ZERO_MUTE_BIT];
		end
		else if (i_clk_en)
		begin
			cp_q      <= cp_d;
			cmd_q     <= cmd_d;
			hdr_cnt_q <= hdr_cnt_d;
			bit_cnt_q <= bit_cnt_d;
			out_sr_q  <= out_sr_d;
			rd_idx_q  <= rd_idx_d;
			dout_oe_q <= dout_oe_d;
			fmt_q     <= fmt_d;
			rb_q      <= rb_d;
			mute_en_q <= mute_en_d;
		end
	end

	// serial audio capture and zero detection
	logic [31:0]  shift_q, shift_d;
	logic [23:0]  i2s_q, i2s_d;
	logic [5:0]   pos_q, pos_d;
	dfz_format_s  act_q, act_d;
	dfz_sample_s  smp_q, smp_d;
	logic [10:0]  run_q [2];
	logic [10:0]  run_d [2];
	logic [1:0]   zero_q, zero_d;
	logic [23:0]  word_val;
	logic         ch;
	// clock output; input clock must stay below half the system clock
	logic         clk_out_q, clk_out_d;
	logic         clk_half_q, clk_half_d;
	logic         clk_oe_q, clk_oe_d;

	always_comb
	begin
		shift_d  = shift_q;
		i2s_d    = i2s_q;
		pos_d    = pos_q;
		act_d    = act_q;
		run_d    = run_q;
		zero_d   = zero_q;
		smp_d    = smp_q;
		smp_d.valid = 1'b0;
		word_val = align_sample(act_q.audio_word_format, shift_q, i2s_q);
		// left is word clock high, except i2s where it is low
		ch = (act_q.audio_word_format == FORMAT_I2S) ? pin_s3_q.word_clock
			: ~pin_s3_q.word_clock;
		if (word_edge)
		begin
			if (word_val != '0)
			begin
				run_d[ch]  = '0;
				zero_d[ch] = 1'b0;
			end
			else if (run_q[ch] != 11'(ZERO_RUN_PERIODS))
			begin
				run_d[ch]  = run_q[ch] + 11'h1;
				zero_d[ch] = (run_q[ch] + 11'h1) == 11'(ZERO_RUN_PERIODS);
			end
			smp_d.valid = 1'b1;
			smp_d.right = ch;
			// mute follows the freshly updated flag, no extra period
			smp_d.data  = (mute_en_q && zero_d[ch]) ? '0 : word_val;
			act_d       = fmt_q;
			pos_d       = '0;
			i2s_d       = '0;
		end
		if (bit_clk_rise)
		begin
			shift_d = {shift_d[30:0], pin_s2_q.audio_data};
			if (pos_d >= 6'(I2S_FIRST_POS) && pos_d < 6'(I2S_FIRST_POS + SAMPLE_BITS))
				i2s_d = {i2s_d[22:0], pin_s2_q.audio_data};
			if (pos_d != 6'h3f)
				pos_d = pos_d + 6'h1;
		end
		clk_half_d = sclk_rise ? ~clk_half_q : clk_half_q;
		clk_out_d  = fmt_q.clock_out_halve ? clk_half_q : pin_s2_q.sys_clk_in;
		clk_oe_d   = ~fmt_q.clock_out_disable;
	end
	always_ff @(posedge i_sys_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			shift_q <= '0;
			i2s_q   <= '0;
			pos_q   <= '0;
			act_q   <= FORMAT_RESET;
			smp_q   <= '0;
			run_q   <= '{default: '0};
			zero_q  <= '0;
			clk_out_q  <= 1'b0;
			clk_half_q <= 1'b0;
			clk_oe_q   <= 1'b0;
		end
		else if (i_clk_en)
		begin
			shift_q <= shift_d;
			i2s_q   <= i2s_d;
			pos_q   <= pos_d;
			act_q   <= act_d;
			smp_q   <= smp_d;
			run_q   <= run_d;
			zero_q  <= zero_d;
			clk_out_q  <= clk_out_d;
			clk_half_q <= clk_half_d;
			clk_oe_q   <= clk_oe_d;
		end
	end

	assign o_ctl_data_out           = out_sr_q[7];
	assign o_ctl_data_out_oe        = dout_oe_q;
	assign o_system_clock_output    = clk_out_q;
	assign o_system_clock_output_oe = clk_oe_q;
	assign o_filter_rolloff_select  = act_q.filter_rolloff_select;
	assign o_interp_rate_select     = act_q.interp_rate_select;
	assign o_sample                 = smp_q;
	assign o_left_zero_flag         = zero_q[0];
	assign o_right_zero_flag        = zero_q[1];
endmodule // dfz_converter_ctrl

// ### tb/dfz_converter_ctrl_monitor.sv
`timescale 1ns/1ns
module dfz_converter_ctrl_monitor (
	input wire logic                 i_sys_clk,
	input wire logic                 i_reset_n,
	input wire logic                 i_ctl_latch_n,
	input wire logic                 i_word_clock,
	input wire logic                 o_ctl_data_out_oe,
	input wire logic [1:0]           o_filter_rolloff_select,
	input wire logic                 o_interp_rate_select,
	input wire dfz_pkg::dfz_sample_s o_sample,
	input wire logic                 o_left_zero_flag,
	input wire logic                 o_right_zero_flag
);
	import dfz_pkg::*;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_reset_n);
	a_left_zero_set: assert property ($rose(o_left_zero_flag) |-> o_sample.valid
		&& !o_sample.right && o_sample.data == 24'h0) else $error("left flag set badly");
	a_right_zero_set: assert property ($rose(o_right_zero_flag) |-> o_sample.valid
		&& o_sample.right && o_sample.data == 24'h0) else $error("right flag set badly");
	a_left_nz_clear: assert property (o_sample.valid && !o_sample.right
		&& o_sample.data != 24'h0 |-> !o_left_zero_flag) else $error("left flag kept");
	a_right_nz_clear: assert property (o_sample.valid && o_sample.right
		&& o_sample.data != 24'h0 |-> !o_right_zero_flag) else $error("right flag kept");
	a_flag_on_slot: assert property ($changed({o_left_zero_flag, o_right_zero_flag})
		|-> o_sample.valid) else $error("flag moved off slot");
	a_roll_at_edge: assert property ($changed(o_filter_rolloff_select)
		|-> $past(i_word_clock, 1) != $past(i_word_clock, 7)) else $error("roll-off moved");
	a_rate_at_edge: assert property ($changed(o_interp_rate_select)
		|-> $past(i_word_clock, 1) != $past(i_word_clock, 7)) else $error("rate moved");
	a_rd_in_frame: assert property ($rose(o_ctl_data_out_oe) |-> !i_ctl_latch_n)
		else $error("readback outside frame");
	c_left_zero: cover property ($rose(o_left_zero_flag));
	c_readback: cover property ($rose(o_ctl_data_out_oe));
	c_rate: cover property ($changed(o_interp_rate_select));
endmodule // dfz_converter_ctrl_monitor

bind dfz_converter_ctrl dfz_converter_ctrl_monitor u_mon (.*);

// ### tb/dfz_host_model.sv
`timescale 1ns/1ns
module dfz_host_model (
	input  wire logic          i_sys_clk,
	input  wire logic          i_rd,
	output dfz_pkg::dfz_pins_s o_pins
);
	import dfz_pkg::*;
	logic [7:0] rq[$];
	initial
	begin
		// frame select idles high, control and bit clocks still
		o_pins = 7'h40;
		forever
		begin
			repeat (4) @(negedge i_sys_clk);
			o_pins.sys_clk_in = ~o_pins.sys_clk_in;
		end
	end
	task automatic frame(input logic [15:0] w, input int n);
		int k;
		logic [7:0] b;
		rq.delete();
		b = 8'h00;
		o_pins.ctl_latch_n = 1'b0;
		for (k = 0; k < (n == 0 ? 16 : 8 + 8 * n); k++)
		begin
			o_pins.ctl_data = (k < 16) ? w[15 - k] : ~o_pins.ctl_data;
			repeat (4) @(negedge i_sys_clk);
			// sample before the rise, device shifts after it
			b = {b[6:0], i_rd};
			if (n > 0 && k >= 15 && k % 8 == 7)
				rq.push_back(b);
			o_pins.ctl_clk = 1'b1;
			repeat (4) @(negedge i_sys_clk);
			o_pins.ctl_clk = 1'b0;
		end
		repeat (4) @(negedge i_sys_clk);
		o_pins.ctl_latch_n = 1'b1;
		o_pins.ctl_data = ~o_pins.ctl_data;
		repeat (8) @(negedge i_sys_clk);
	endtask
	task automatic slot(input logic [24:0] v, input int nb, input logic lvl);
		int k;
		o_pins.word_clock = lvl;
		repeat (8) @(negedge i_sys_clk);
		for (k = nb - 1; k >= 0; k--)
		begin
			o_pins.audio_data = v[k];
			repeat (3) @(negedge i_sys_clk);
			o_pins.bit_clk = 1'b1;
			repeat (3) @(negedge i_sys_clk);
			o_pins.bit_clk = 1'b0;
		end
		o_pins.audio_data = ~o_pins.audio_data;
	endtask
endmodule // dfz_host_model

// ### tb/tb_dfz_converter_ctrl.sv
`timescale 1ns/1ns
module tb_dfz_converter_ctrl;
	import dfz_pkg::*;
	logic        clk, clk_en, rst_n, rd, rd_oe, sco, sco_oe, rate, zl, zr;
	logic [1:0]  roll;
	dfz_pins_s   pins;
	dfz_sample_s smp;
	dfz_sample_s sq[$];
	int          error_cnt, tests_run;
	dfz_host_model host (.i_sys_clk(clk), .i_rd(rd), .o_pins(pins));
	dfz_converter_ctrl DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
		.i_ctl_latch_n(pins.ctl_latch_n), .i_ctl_clk(pins.ctl_clk), .i_ctl_data(pins.ctl_data),
		.i_bit_clk(pins.bit_clk), .i_word_clock(pins.word_clock),
		.i_audio_data(pins.audio_data), .i_sys_clk_in(pins.sys_clk_in),
		.o_ctl_data_out(rd), .o_ctl_data_out_oe(rd_oe), .o_system_clock_output(sco),
		.o_system_clock_output_oe(sco_oe), .o_filter_rolloff_select(roll),
		.o_interp_rate_select(rate), .o_sample(smp), .o_left_zero_flag(zl),
		.o_right_zero_flag(zr));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(negedge clk)
		if (smp.valid === 1'b1)
			sq.push_back(smp);
	task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e)
		begin
			$display("[ERR] %s exp %h got %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		host.frame({1'b0, a, d}, 0);
	endtask
	task results;
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task t_reset;
		chk("clk_oe", 24'h1, sco_oe);
		chk("roll_rate", 24'h0, {roll, rate});
		chk("flags", 24'h0, {zl, zr});
		wr(REG_INDEX_READBACK, 8'h15);
		// readback byte is driven between the eighth and sixteenth clock
		fork
			host.frame(16'h8000, 1);
			begin
				repeat (96) @(negedge clk);
				chk("rd_oe_on", 24'h1, rd_oe);
			end
		join
		chk("rd_oe_off", 24'h0, rd_oe);
		chk("rb_self", 24'h15, host.rq[0]);
	endtask
	task t_auto;
		int j;
		wr(REG_INDEX_READBACK, 8'h95);
		host.frame(16'h8000, 21);
		chk("auto_len", 24'h15, 24'(host.rq.size()));
		for (j = 0; j < 21; j++)
			chk("auto_byte", j == 20 ? 24'h95 : 24'h0, host.rq[j]);
		wr(REG_INDEX_ATTEN_CTRL, 8'h10);
		wr(REG_INDEX_READBACK, 8'h12);
		host.frame(16'h8000, 1);
		chk("mute_en", 24'h10, host.rq[0]);
	endtask
	task t_roll;
		int c;
		logic [2:0] prev;
		prev = 3'h0;
		for (c = 0; c < 3; c++)
		begin
			// slow roll-off only paired with 8x
			wr(REG_INDEX_FORMAT, {c == 0, 2'(c), 5'h00});
			chk("hold", prev, {rate, roll});
			host.slot(25'h0, 0, 1'b1);
			host.slot(25'h0, 0, 1'b0);
			prev = {c == 0, 2'(c)};
			chk("active", prev, {rate, roll});
		end
	endtask
	task t_clkout;
		int h;
		logic [23:0] n;
		logic lst;
		for (h = 0; h < 2; h++)
		begin
			wr(REG_INDEX_FORMAT, {3'h0, h == 1, 4'h0});
			repeat (16) @(negedge clk);
			n = 24'h0;
			lst = sco;
			repeat (64)
			begin
				@(negedge clk);
				n = n + 24'(sco !== lst);
				lst = sco;
			end
			chk("clk_edges", h == 1 ? 24'h8 : 24'h10, n);
		end
		// low enable must hold the divided clock still
		n = 24'h0;
		lst = sco;
		clk_en = 1'b0;
		repeat (32)
		begin
			@(negedge clk);
			n = n + 24'(sco !== lst);
		end
		clk_en = 1'b1;
		chk("clk_frozen", 24'h0, n);
		wr(REG_INDEX_FORMAT, 8'h08);
		chk("clk_oe_off", 24'h0, sco_oe);
		wr(REG_INDEX_FORMAT, 8'h00);
		chk("clk_oe_on", 24'h1, sco_oe);
	endtask
	task t_audio;
		int c, w;
		logic [23:0] dl, dr;
		logic lv;
		for (c = 0; c < 8; c++)
		begin
			w = (c > 0 && c < 4) ? 22 - 2 * c : 24;
			lv = (c != 4);
			dl = 24'h9a5c31 + 24'(c);
			dr = 24'h3c96a5 - 24'(c);
			wr(REG_INDEX_FORMAT, 8'(c));
			host.slot(25'h0, 0, lv);
			host.slot(25'h0, 0, ~lv);
			sq.delete();
			host.slot({c == 4, dl}, w + (c == 4), lv);
			host.slot({c == 4, dr}, w + (c == 4), ~lv);
			host.slot(25'h0, 0, lv);
			// entry 0 is the empty slot closed by the first data edge
			chk("count", 24'h3, 24'(sq.size()));
			chk("left", dl << (24 - w), sq[1].data);
			chk("right", dr << (24 - w), sq[2].data);
			chk("sides", 24'h1, {sq[1].right, sq[2].right});
		end
	endtask
	task t_zero;
		int i;
		host.slot(25'h1, 24, 1'b1);
		host.slot(25'h1, 24, 1'b0);
		// one full zero word flushes the shifter, then short slots
		for (i = 1; i < 1024; i++)
		begin
			host.slot(25'h0, i == 1 ? 24 : 1, 1'b1);
			host.slot(25'h0, i == 1 ? 24 : 1, 1'b0);
		end
		host.slot(25'h0, 1, 1'b1);
		chk("zero_1023", 24'h0, {zl, zr});
		host.slot(25'h0, 1, 1'b0);
		chk("zero_left", 24'h2, {zl, zr});
		host.slot(25'h1, 24, 1'b1);
		chk("zero_both", 24'h3, {zl, zr});
		host.slot(25'h0, 0, 1'b0);
		chk("zero_clear", 24'h1, {zl, zr});
		chk("unmuted", 24'h1, sq[$].data);
	endtask
	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		clk_en = 1'b1;
		rst_n = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset;
		t_auto;
		t_roll;
		t_clkout;
		t_audio;
		t_zero;
		results;
	end
endmodule // tb_dfz_converter_ctrl
